// [rtl/dbspl_pkg.sv]
package dbspl_pkg;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned LANES      = 4;
  localparam int unsigned DATA_W     = LANE_W * LANES;
  localparam int unsigned OUT_STAGES = 4;
  localparam int unsigned REG_AW     = 4;
  localparam int unsigned BUS_W      = 32;
  localparam int unsigned STRB_W     = BUS_W / 8;
  localparam int unsigned SYNC_CTL_W = 7;

  localparam logic [REG_AW-1:0] CONFIG_OFFSET = 4'h0;
  localparam logic [REG_AW-1:0] STATUS_OFFSET = 4'h4;

  localparam logic [1:0] WIDTH_X36    = 2'h0;
  localparam logic [1:0] WIDTH_X18    = 2'h1;
  localparam logic [1:0] WIDTH_X9     = 2'h2;
  localparam logic [1:0] CONFIG_RESET = WIDTH_X36;

  localparam int unsigned STATUS_SINGLE_BIT = 0;
  localparam int unsigned STATUS_LAT1_BIT   = 1;
  localparam int unsigned STATUS_DRIVE_BIT  = 2;
  localparam int unsigned STATUS_WBUSY_BIT  = 3;
  localparam int unsigned STATUS_RBUSY_BIT  = 4;

  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : dbspl_pkg

// [rtl/dbspl_sync.sv]
`timescale 1ns/10ps
module dbspl_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // meta is read by the second stage only
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : dbspl_sync

// [rtl/dbspl_mem.sv]
`timescale 1ns/10ps
module dbspl_mem #(
  parameter int unsigned AW     = 9,
  parameter int unsigned LANE_W = 9,
  parameter int unsigned LANES  = 4
) (
  input  wire logic                      clock_in,
  input  wire logic                      reset_in,
  input  wire logic                      wr_en_in,
  input  wire logic [AW-1:0]             wr_addr_in,
  input  wire logic [LANES-1:0]          wr_lane_in,
  input  wire logic [LANE_W*LANES-1:0]   wr_data_in,
  input  wire logic [AW-1:0]             rd_addr_in,
  output logic      [LANE_W*LANES-1:0]   rd_data_out
);
  logic [LANE_W*LANES-1:0] array [0:(1<<AW)-1];

  // lanes not enabled keep their stored contents
  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_lane_in[i]) begin
          array[wr_addr_in][i*LANE_W +: LANE_W] <= wr_data_in[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= array[rd_addr_in];
    end
  end
endmodule : dbspl_mem

// [rtl/dbspl_port_logic.sv]
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// How it works
// - write opens on k rise, word0 there
// - write address latched on k_n rise
// - read latches address on k rise
// - burst words go to address plus zero, one
// - output edges from c pair, or k pair
// - after reset deselected, read bus undriven
// - each half samples its own masks
// - x18 masks guard lanes 0 and 1
// - x9 single mask guards lane 0
// - x36 all masks low stores whole word
// - x36 mask bits map to four lanes
// - all masks high stores nothing, burst continues
// - delay loop off gives one-cycle latency
// - bus released one output edge after word1
// - read after write sees newest data
module dbspl_port_logic #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                           clock_in,
  input  wire logic                           reset_in,
  input  wire logic                           k_in,
  input  wire logic                           k_n_in,
  input  wire logic                           c_in,
  input  wire logic                           c_n_in,
  input  wire logic                           read_port_sel_n_in,
  input  wire logic                           write_port_sel_n_in,
  input  wire logic [ADDR_W-1:0]              addr_in,
  input  wire logic [dbspl_pkg::DATA_W-1:0]   data_in,
  input  wire logic [dbspl_pkg::LANES-1:0]    lane_write_mask_n_in,
  input  wire logic                           delay_loop_off_n_in,
  output logic      [dbspl_pkg::DATA_W-1:0]   q_out,
  output logic                                q_oe_out,
  input  wire logic [dbspl_pkg::REG_AW-1:0]   s_axi_awaddr_in,
  input  wire logic                           s_axi_awvalid_in,
  output logic                                s_axi_awready_out,
  input  wire logic [dbspl_pkg::BUS_W-1:0]    s_axi_wdata_in,
  input  wire logic [dbspl_pkg::STRB_W-1:0]   s_axi_wstrb_in,
  input  wire logic                           s_axi_wvalid_in,
  output logic                                s_axi_wready_out,
  output logic      [1:0]                     s_axi_bresp_out,
  output logic                                s_axi_bvalid_out,
  input  wire logic                           s_axi_bready_in,
  input  wire logic [dbspl_pkg::REG_AW-1:0]   s_axi_araddr_in,
  input  wire logic                           s_axi_arvalid_in,
  output logic                                s_axi_arready_out,
  output logic      [dbspl_pkg::BUS_W-1:0]    s_axi_rdata_out,
  output logic      [1:0]                     s_axi_rresp_out,
  output logic                                s_axi_rvalid_out,
  input  wire logic                           s_axi_rready_in
);
  import dbspl_pkg::*;

  localparam int unsigned SYNC_W = SYNC_CTL_W + LANES + ADDR_W + DATA_W;
  localparam int unsigned MEM_AW = ADDR_W + 1;

  if (ADDR_W < 1 || ADDR_W > 20) begin : g_check
    $error("ADDR_W must lie between 1 and 20");
  end

  typedef enum logic [1:0] {WR_IDLE, WR_HALF1, WR_COMMIT0, WR_COMMIT1} dbspl_wr_state_type;
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH0, RD_FETCH1, RD_FETCH2} dbspl_rd_state_type;

  typedef struct packed {
    logic [DATA_W-1:0] word0;
    logic [DATA_W-1:0] word1;
  } dbspl_slot_type;

  typedef struct packed {
    logic                            k;
    logic                            k_n;
    logic                            c;
    logic                            c_n;
    logic [1:0]                      strap_cnt;
    logic                            strap_done;
    logic                            single_clock;
    dbspl_wr_state_type              wr_state;
    logic [ADDR_W-1:0]               wr_addr;
    logic [DATA_W-1:0]               wr_word0;
    logic [DATA_W-1:0]               wr_word1;
    logic [LANES-1:0]                wr_mask0;
    logic [LANES-1:0]                wr_mask1;
    dbspl_rd_state_type              rd_state;
    logic [ADDR_W-1:0]               rd_addr;
    logic                            pend_valid;
    dbspl_slot_type                  pend;
    logic [OUT_STAGES-1:0]           stage_valid;
    dbspl_slot_type [OUT_STAGES-2:0] stage_data;
    logic [DATA_W-1:0]               q;
    logic                            q_oe;
    logic [1:0]                      width_mode;
    logic                            aw_held;
    logic [REG_AW-1:0]               aw_addr;
    logic                            w_held;
    logic [BUS_W-1:0]                w_data;
    logic [STRB_W-1:0]               w_strb;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            rvalid;
    logic [BUS_W-1:0]                rdata;
    logic [1:0]                      rresp;
  } dbspl_state_type;

  dbspl_state_type   st;
  dbspl_state_type   next_st;
  logic [SYNC_W-1:0] sync_q;
  logic              k_s;
  logic              k_n_s;
  logic              c_s;
  logic              c_n_s;
  logic              rps_n_s;
  logic              wps_n_s;
  logic              delay_loop_off_n_n_s;
  logic [LANES-1:0]  mask_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic              k_rise;
  logic              k_n_rise;
  logic              out_edge;
  logic              lat_one;
  logic              rd_start;
  logic              mem_wr_en;
  logic [MEM_AW-1:0] mem_wr_addr;
  logic [LANES-1:0]  mem_wr_lane;
  logic [DATA_W-1:0] mem_wr_data;
  logic [MEM_AW-1:0] mem_rd_addr;
  logic [DATA_W-1:0] mem_rd_data;
  logic [BUS_W-1:0]  status_word;

  // data and controls share the clocks' two-stage delay, so they stay aligned to the edges
  dbspl_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in ({k_in, k_n_in, c_in, c_n_in, read_port_sel_n_in, write_port_sel_n_in,
                delay_loop_off_n_in, lane_write_mask_n_in, addr_in, data_in}),
    .sync_out (sync_q)
  );

  assign {k_s, k_n_s, c_s, c_n_s, rps_n_s, wps_n_s, delay_loop_off_n_n_s, mask_s, addr_s, data_s} = sync_q;

  // no write, read or output edge starts before the straps are taken
  assign k_rise   = st.strap_done & k_s & ~st.k;
  assign k_n_rise = st.strap_done & k_n_s & ~st.k_n;
  assign out_edge = st.strap_done & (st.single_clock ? ((k_s & ~st.k) | (k_n_s & ~st.k_n))
                                                     : ((c_s & ~st.c) | (c_n_s & ~st.c_n)));
  assign lat_one  = ~delay_loop_off_n_n_s;
  assign rd_start = k_rise & ~rps_n_s & (st.rd_state == RD_IDLE);

  function automatic logic [LANES-1:0] lane_enable(input logic [1:0]       mode,
                                                   input logic [LANES-1:0] mask_n);
    logic [LANES-1:0] en;
    en = ~mask_n;
    if (mode == WIDTH_X9) begin
      en = {{(LANES-1){1'b0}}, ~mask_n[0]};
    end else if (mode == WIDTH_X18) begin
      en = {{(LANES-2){1'b0}}, ~mask_n[1:0]};
    end
    return en;
  endfunction : lane_enable

  // all masks high gives no lanes, yet both commit cycles still run
  assign mem_wr_en   = (st.wr_state == WR_COMMIT0) | (st.wr_state == WR_COMMIT1);
  assign mem_wr_lane = lane_enable(st.width_mode, (st.wr_state == WR_COMMIT1) ? st.wr_mask1
                                                                             : st.wr_mask0);
  assign mem_wr_data = (st.wr_state == WR_COMMIT1) ? st.wr_word1 : st.wr_word0;
  assign mem_wr_addr = {st.wr_addr, 1'b0} + {{ADDR_W{1'b0}}, st.wr_state == WR_COMMIT1};
  assign mem_rd_addr = {st.rd_addr, 1'b0} + {{ADDR_W{1'b0}}, st.rd_state == RD_FETCH1};

  dbspl_mem #(.AW(MEM_AW), .LANE_W(LANE_W), .LANES(LANES)) u_mem (
    .clock_in    (clock_in),
    .reset_in    (reset_in),
    .wr_en_in    (mem_wr_en),
    .wr_addr_in  (mem_wr_addr),
    .wr_lane_in  (mem_wr_lane),
    .wr_data_in  (mem_wr_data),
    .rd_addr_in  (mem_rd_addr),
    .rd_data_out (mem_rd_data)
  );

  always_comb begin
    status_word = '0;
    status_word[STATUS_SINGLE_BIT] = st.single_clock;
    status_word[STATUS_LAT1_BIT]   = lat_one;
    status_word[STATUS_DRIVE_BIT]  = st.q_oe;
    status_word[STATUS_WBUSY_BIT]  = st.wr_state != WR_IDLE;
    status_word[STATUS_RBUSY_BIT]  = (st.rd_state != RD_IDLE) | st.pend_valid | (|st.stage_valid);
  end

  always_comb begin
    next_st = st;
    next_st.k   = k_s;
    next_st.k_n = k_n_s;
    next_st.c   = c_s;
    next_st.c_n = c_n_s;

    // wait until the synchroniser holds real pin levels before reading the strap
    if (!st.strap_done) begin
      if (st.strap_cnt == STRAP_WAIT) begin
        next_st.strap_done   = 1'b1;
        next_st.single_clock = c_s & c_n_s;
      end else begin
        next_st.strap_cnt = st.strap_cnt + 2'h1;
      end
    end

    unique case (st.wr_state)
      WR_IDLE: begin
        if (k_rise && !wps_n_s) begin
          next_st.wr_state = WR_HALF1;
          next_st.wr_word0 = data_s;
          next_st.wr_mask0 = mask_s;
        end
      end
      WR_HALF1: begin
        if (k_n_rise) begin
          next_st.wr_state = WR_COMMIT0;
          next_st.wr_addr  = addr_s;
          next_st.wr_word1 = data_s;
          next_st.wr_mask1 = mask_s;
        end
      end
      // both words land two cycles after k_n, well before the next k rise, so a read
      // started there already fetches the newest data
      WR_COMMIT0: next_st.wr_state = WR_COMMIT1;
      WR_COMMIT1: next_st.wr_state = WR_IDLE;
    endcase

    unique case (st.rd_state)
      RD_IDLE: begin
        if (rd_start) begin
          next_st.rd_state = RD_FETCH0;
          next_st.rd_addr  = addr_s;
        end
      end
      RD_FETCH0: next_st.rd_state = RD_FETCH1;
      RD_FETCH1: begin
        next_st.pend.word0 = mem_rd_data;
        next_st.rd_state   = RD_FETCH2;
      end
      RD_FETCH2: begin
        next_st.pend.word1 = mem_rd_data;
        next_st.rd_state   = RD_IDLE;
      end
    endcase

    // one stage per output edge; the newest read wins so back-to-back bursts run seamless
    if (out_edge) begin
      next_st.stage_valid = {st.stage_valid[OUT_STAGES-2:0], st.pend_valid};
      next_st.stage_data  = {st.stage_data[OUT_STAGES-3:0], st.pend};
      next_st.pend_valid  = 1'b0;
      if (lat_one) begin
        if (st.stage_valid[0]) begin
          next_st.q    = st.stage_data[0].word0;
          next_st.q_oe = 1'b1;
        end else if (st.stage_valid[1]) begin
          next_st.q = st.stage_data[1].word1;
        end else if (st.stage_valid[2]) begin
          next_st.q_oe = 1'b0;
        end
      end else begin
        if (st.stage_valid[1]) begin
          next_st.q    = st.stage_data[1].word0;
          next_st.q_oe = 1'b1;
        end else if (st.stage_valid[2]) begin
          next_st.q = st.stage_data[2].word1;
        end else if (st.stage_valid[3]) begin
          next_st.q_oe = 1'b0;
        end
      end
    end
    if (rd_start) begin
      next_st.pend_valid = 1'b1;
    end

    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata_in;
      next_st.w_strb = s_axi_wstrb_in;
    end
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = AXI_OKAY;
      if (st.aw_addr[REG_AW-1:2] == CONFIG_OFFSET[REG_AW-1:2]) begin
        if (st.w_strb[0]) begin
          next_st.width_mode = st.w_data[1:0];
        end
      end else if (st.aw_addr[REG_AW-1:2] != STATUS_OFFSET[REG_AW-1:2]) begin
        next_st.bresp = AXI_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end

    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = AXI_OKAY;
      if (s_axi_araddr_in[REG_AW-1:2] == CONFIG_OFFSET[REG_AW-1:2]) begin
        next_st.rdata = {{(BUS_W-2){1'b0}}, st.width_mode};
      end else if (s_axi_araddr_in[REG_AW-1:2] == STATUS_OFFSET[REG_AW-1:2]) begin
        next_st.rdata = status_word;
      end else begin
        next_st.rdata = '0;
        next_st.rresp = AXI_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
  end

  // reset leaves both ports deselected and the read bus released
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out             = st.q;
  assign q_oe_out          = st.q_oe;
  assign s_axi_awready_out = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready_out  = ~st.w_held & ~st.bvalid;
  assign s_axi_bvalid_out  = st.bvalid;
  assign s_axi_bresp_out   = st.bresp;
  assign s_axi_arready_out = ~st.rvalid;
  assign s_axi_rvalid_out  = st.rvalid;
  assign s_axi_rdata_out   = st.rdata;
  assign s_axi_rresp_out   = st.rresp;

  default clocking dbspl_cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_commit_pair;
    st.wr_state == WR_COMMIT0 ##1 st.wr_state == WR_COMMIT1 ##1 st.wr_state == WR_IDLE;
  endsequence

  sequence s_fetch_run;
    st.rd_state == RD_FETCH0 ##1 st.rd_state == RD_FETCH1 ##1 st.rd_state == RD_FETCH2;
  endsequence

  a_write_open: assert property (
    k_rise && !wps_n_s && st.wr_state == WR_IDLE |=> st.wr_state == WR_HALF1
      && st.wr_word0 == $past(data_s) && st.wr_mask0 == $past(mask_s))
    else $error("write did not open on k rise");

  a_addr_on_kn: assert property (
    st.wr_state == WR_HALF1 && k_n_rise |=> st.wr_addr == $past(addr_s) ##0 s_commit_pair)
    else $error("write address not taken on k_n rise");

  a_burst_pair: assert property (
    st.wr_state == WR_COMMIT0 |=> mem_wr_en && mem_wr_addr == $past(mem_wr_addr) + 1'b1)
    else $error("second burst word not at address plus one");

  a_read_fetch: assert property (
    rd_start |=> st.rd_addr == $past(addr_s) ##0 s_fetch_run ##1 st.pend.word1 == $past(mem_rd_data))
    else $error("read fetch sequence broken");

  a_masked_half: assert property (
    st.wr_state == WR_COMMIT0 && &st.wr_mask0 |-> mem_wr_lane == '0 ##1 st.wr_state == WR_COMMIT1)
    else $error("fully masked half stored data or stopped the burst");

  a_x9_lane: assert property (
    mem_wr_en && st.width_mode == WIDTH_X9 |-> mem_wr_lane[LANES-1:1] == '0
      && mem_wr_lane[0] == !(st.wr_state == WR_COMMIT1 ? st.wr_mask1[0] : st.wr_mask0[0]))
    else $error("x9 lane enable wrong");

  a_x18_lanes: assert property (
    mem_wr_en && st.width_mode == WIDTH_X18 |-> mem_wr_lane[LANES-1:2] == '0
      && mem_wr_lane[1:0] == ~(st.wr_state == WR_COMMIT1 ? st.wr_mask1[1:0] : st.wr_mask0[1:0]))
    else $error("x18 lane enables wrong");

  a_x36_lanes: assert property (
    mem_wr_en && st.width_mode == WIDTH_X36
      |-> mem_wr_lane == ~(st.wr_state == WR_COMMIT1 ? st.wr_mask1 : st.wr_mask0))
    else $error("x36 lane enables wrong");

  a_nop_idle: assert property (
    k_rise && wps_n_s && st.wr_state == WR_IDLE |=> st.wr_state == WR_IDLE)
    else $error("write started while deselected");

  a_drive_at_edge: assert property (
    $changed(st.q_oe) |-> $past(out_edge))
    else $error("read bus enable moved off an output edge");

  a_lat_one: assert property (
    out_edge && lat_one && st.stage_valid[0] |=> st.q_oe && st.q == $past(st.stage_data[0].word0))
    else $error("one-cycle latency word0 not launched");
endmodule : dbspl_port_logic

// [sim/dbspl_host.sv]
`timescale 1ns/10ps
module dbspl_host (
  input  wire logic                         clock_in,
  input  wire logic                         single_in,
  input  wire logic [dbspl_pkg::DATA_W-1:0] q_in,
  input  wire logic                         q_oe_in,
  output logic                              k_out,
  output logic                              k_n_out,
  output logic                              c_out,
  output logic                              c_n_out,
  output logic                              read_port_sel_n_out,
  output logic                              write_port_sel_n_out,
  output logic      [7:0]                   addr_out,
  output logic      [dbspl_pkg::DATA_W-1:0] data_out,
  output logic      [dbspl_pkg::LANES-1:0]  lane_write_mask_n_out
);
  import dbspl_pkg::*;
  logic [DATA_W-1:0] q_k, q_kn;
  logic              oe_k, oe_kn;
  initial begin
    k_out = 1'b0;
    k_n_out = 1'b0;
    c_out = 1'b0;
    c_n_out = 1'b0;
    read_port_sel_n_out = 1'b1;
    write_port_sel_n_out = 1'b1;
    addr_out = 8'h00;
    data_out = '0;
    lane_write_mask_n_out = '1;
  end
  // one half period is four system clocks; q is taken just before the next edge
  task automatic half(input logic kh, input logic rs, input logic ws, input logic [7:0] a,
                      input logic [DATA_W-1:0] d, input logic [LANES-1:0] m,
                      output logic [DATA_W-1:0] q, output logic oe);
    k_out <= kh;
    k_n_out <= !kh;
    c_out <= single_in | kh;
    c_n_out <= single_in | !kh;
    read_port_sel_n_out <= rs;
    write_port_sel_n_out <= ws;
    addr_out <= a;
    data_out <= d;
    lane_write_mask_n_out <= m;
    repeat (4) @(posedge clock_in);
    q = q_in;
    oe = q_oe_in;
  endtask : half
  task automatic kcycle(input logic rs, input logic ws, input logic [7:0] ra,
                        input logic [7:0] wa, input logic [DATA_W-1:0] d0,
                        input logic [LANES-1:0] m0, input logic [DATA_W-1:0] d1,
                        input logic [LANES-1:0] m1);
    half(1'b1, rs, ws, ra, d0, m0, q_k, oe_k);
    half(1'b0, 1'b1, 1'b1, wa, d1, m1, q_kn, oe_kn);
  endtask : kcycle
  // c pair rests low in two-clock mode: a high rest could not mark the next k rise
  task automatic stop();
    k_out <= 1'b0;
    k_n_out <= 1'b0;
    c_out <= single_in;
    c_n_out <= single_in;
    read_port_sel_n_out <= 1'b1;
    write_port_sel_n_out <= 1'b1;
    addr_out <= ~addr_out;
    data_out <= ~data_out;
    repeat (8) @(posedge clock_in);
  endtask : stop
endmodule : dbspl_host

// [sim/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import dbspl_pkg::*;
  logic              clock_in, reset_in, single, delay_loop_off_n_in, q_oe_out;
  logic              k_in, k_n_in, c_in, c_n_in, read_port_sel_n_in, write_port_sel_n_in;
  logic [7:0]        addr_in;
  logic [DATA_W-1:0] data_in, q_out, mem_m [0:511];
  logic [LANES-1:0]  lane_write_mask_n_in;
  logic [REG_AW-1:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [BUS_W-1:0]  s_axi_wdata_in, s_axi_rdata_out, rd;
  logic [STRB_W-1:0] s_axi_wstrb_in;
  logic [1:0]        s_axi_bresp_out, s_axi_rresp_out, mode, rsp;
  logic              s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic              s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic              s_axi_rvalid_out, s_axi_rready_in;
  int                err_count = 0;
  int                num_checks = 0;
  dbspl_port_logic #(.ADDR_W(8)) dut (.clock_in, .reset_in, .k_in, .k_n_in, .c_in, .c_n_in,
    .read_port_sel_n_in, .write_port_sel_n_in, .addr_in, .data_in, .lane_write_mask_n_in,
    .delay_loop_off_n_in, .q_out, .q_oe_out, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);
  dbspl_host host (.clock_in, .single_in(single), .q_in(q_out), .q_oe_in(q_oe_out),
    .k_out(k_in), .k_n_out(k_n_in), .c_out(c_in), .c_n_out(c_n_in),
    .read_port_sel_n_out(read_port_sel_n_in), .write_port_sel_n_out(write_port_sel_n_in),
    .addr_out(addr_in), .data_out(data_in), .lane_write_mask_n_out(lane_write_mask_n_in));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // no local limit: only the watchdog ends a wait for the answer
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    rsp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
    @(posedge clock_in);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    rd = s_axi_rdata_out;
    rsp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    @(posedge clock_in);
  endtask : axi_rd
  // write a, read a on the next k rise, then two idle cycles to see the burst out
  task automatic burst(input logic [7:0] a, input logic [35:0] d0, d1,
                       input logic [3:0] m0, m1);
    logic [35:0] keep;
    logic [3:0]  lv;
    lv = (mode == WIDTH_X18) ? 4'h3 : ((mode == WIDTH_X9) ? 4'h1 : 4'hF);
    keep = (mode == WIDTH_X18) ? 36'h00003FFFF : ((mode == WIDTH_X9) ? 36'h0000001FF : '1);
    for (int i = 0; i < 4; i++) begin
      if (lv[i] && !m0[i]) mem_m[{a, 1'b0}][i*9 +: 9] = d0[i*9 +: 9];
      if (lv[i] && !m1[i]) mem_m[{a, 1'b1}][i*9 +: 9] = d1[i*9 +: 9];
    end
    host.kcycle(1'b1, 1'b0, ~a, a, d0, m0, d1, m1);
    chk("oe idle", 36'h0, {35'h0, host.oe_kn});
    host.kcycle(1'b0, 1'b1, a, ~a, ~d0, 4'h0, ~d1, 4'h0);
    host.kcycle(1'b1, 1'b1, ~a, ~a, d0, 4'h0, d1, 4'h0);
    if (!delay_loop_off_n_in) begin
      chk("word0", mem_m[{a, 1'b0}] & keep, host.q_k & keep);
      chk("word1", mem_m[{a, 1'b1}] & keep, host.q_kn & keep);
      chk("oe on", 36'h1, {35'h0, host.oe_kn});
    end else begin
      chk("word0", mem_m[{a, 1'b0}] & keep, host.q_kn & keep);
    end
    host.kcycle(1'b1, 1'b1, a, a, d1, 4'h0, d0, 4'h0);
    if (!delay_loop_off_n_in) begin
      chk("release", 36'h0, {35'h0, host.oe_k});
    end else begin
      chk("word1", mem_m[{a, 1'b1}] & keep, host.q_k & keep);
      chk("oe on", 36'h1, {35'h0, host.oe_k});
      chk("release", 36'h0, {35'h0, host.oe_kn});
    end
    host.stop();
    $display("test burst at %h done", a);
  endtask : burst
  initial begin
    reset_in = 1'b1;
    single = 1'b0;
    delay_loop_off_n_in = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    s_axi_awaddr_in = 4'h0;
    s_axi_araddr_in = 4'h0;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'hF;
    mode = WIDTH_X36;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    host.stop();
    axi_rd(CONFIG_OFFSET);
    chk("config", {34'h0, CONFIG_RESET}, {34'h0, rd[1:0]});
    axi_rd(STATUS_OFFSET);
    chk("status", 36'h0, {33'h0, rd[2:0]});
    axi_rd(4'h8);
    chk("unmapped", {34'h0, AXI_SLVERR}, {34'h0, rsp});
    burst(8'h05, 36'h123456789, 36'hABCDEF012, 4'h0, 4'h0);
    burst(8'h05, 36'h0FEDCBA98, 36'h111111111, 4'hF, 4'hA);
    delay_loop_off_n_in <= 1'b0;
    host.stop();
    axi_rd(STATUS_OFFSET);
    chk("latency", 36'h1, {35'h0, rd[STATUS_LAT1_BIT]});
    mode = WIDTH_X18;
    axi_wr(CONFIG_OFFSET, {30'h0, mode});
    chk("bresp", {34'h0, AXI_OKAY}, {34'h0, rsp});
    burst(8'h05, 36'h2468ACE02, 36'h13579BDF1, 4'hD, 4'h0);
    mode = WIDTH_X9;
    axi_wr(CONFIG_OFFSET, {30'h0, mode});
    chk("bresp", {34'h0, AXI_OKAY}, {34'h0, rsp});
    burst(8'h05, 36'h0000000AB, 36'h0000000CD, 4'hE, 4'h1);
    single <= 1'b1;
    delay_loop_off_n_in <= 1'b1;
    @(posedge clock_in);
    host.stop();
    reset_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    mode = WIDTH_X36;
    host.stop();
    axi_rd(STATUS_OFFSET);
    chk("single", 36'h1, {35'h0, rd[STATUS_SINGLE_BIT]});
    burst(8'h21, 36'h5A5A5A5A5, 36'hC3C3C3C3C, 4'h0, 4'h0);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clock_in);
    err_count++;
    finish_test();
  end
endmodule : testbench
